//--- verilog/adsc_pkg.sv
// Behaviour
// - chip select falling resets counters, enables port
// - chip select rising disables input and clock
// - four code bits captured msb first
// - next four rising edges load configuration
// - eight bits captured, channel applied after fourth
// - sampling runs fourth fall to last fall
// - result output released while chip select high
// - first result bit driven at select, advance on fall
// - remaining eleven bits shift on falling edges only
// - last falling edge hands over to converter
// - interrupt mode: status falls when result ready
// - interrupt mode: status rises on clock rise
// - end mode: low after last fall until done
// - mux picks eleven inputs or three test levels
// - reference external or internal, two internal levels
// - result bit order msb or lsb first
// - result coding unipolar or bipolar
// - clock idle low, sample rise, change fall
// - status pin selectable interrupt or end mode
// - self test codes give 2048, 0, 4095
package adsc_pkg;
  localparam int unsigned RES_W        = 12;
  localparam int unsigned CODE_W       = 4;
  localparam int unsigned CFG_W        = 4;
  localparam int unsigned CNT_W        = 5;
  localparam logic [CNT_W-1:0] CODE_EDGES  = 5'h04;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h08;
  localparam logic [CNT_W-1:0] LEN8        = 5'h08;
  localparam logic [CNT_W-1:0] LEN12       = 5'h0C;
  localparam logic [CNT_W-1:0] LEN16       = 5'h10;
  // last analog input code, then the self-test and command codes above it
  localparam logic [CODE_W-1:0] LAST_AIN   = 4'hA;
  localparam logic [CODE_W-1:0] TEST_MID   = 4'hB;
  localparam logic [CODE_W-1:0] TEST_ZERO  = 4'hC;
  localparam logic [CODE_W-1:0] TEST_FULL  = 4'hD;
  localparam logic [CODE_W-1:0] CMD_CFG2   = 4'hF;
  localparam logic [RES_W-1:0]  RES_MID    = 12'h800;
  localparam logic [RES_W-1:0]  RES_ZERO   = 12'h000;
  localparam logic [RES_W-1:0]  RES_FULL   = 12'hFFF;
  localparam logic [RES_W-1:0]  BIPOLAR_FLIP = 12'h800;
  // conversion time in ns, rounded up to clock cycles
  localparam int unsigned CLK_NS       = 40;
  localparam int unsigned CONV_NS      = 4150;
  localparam int unsigned CONV_CYC     = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_W       = 8;
  // configuration nibble fields
  localparam int unsigned CFG_LSBF     = 0;
  localparam int unsigned CFG_BIP      = 1;
  localparam int unsigned CFG_LEN_LO   = 2;
  localparam int unsigned CFG2_INT     = 3;
  localparam int unsigned CFG2_REFINT  = 2;
  localparam int unsigned CFG2_REF4V   = 1;

  // packed msb first: length in bits 3:2, coding in 1, bit order in 0
  typedef struct packed {
    logic [1:0] len_sel;
    logic       bipolar;
    logic       lsb_first;
  } adsc_cfg_t;

  typedef struct packed {
    logic       status_int;
    logic       ref_internal;
    logic       ref_high;
    logic       spare;
  } adsc_cfg2_t;
endpackage

//--- verilog/adsc_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two flop synchroniser; first stage read only by second
module adsc_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // async level in, synced out
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // reset constant only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- verilog/adsc_conv.sv
`timescale 1ns/100ps
`default_nettype none
// conversion timer standing in for the oscillator-driven state controller
module adsc_conv (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // start pulse and sample to convert
  input  wire logic                        start,
  input  wire logic [adsc_pkg::RES_W-1:0]  sample,
  // result
  output logic                             busy,
  output logic                             done,
  output logic [adsc_pkg::RES_W-1:0]       result
);
  logic [adsc_pkg::CONV_W-1:0] cnt_q;
  logic [adsc_pkg::RES_W-1:0]  smp_q;
  wire  last_w = busy && (cnt_q == adsc_pkg::CONV_W'(adsc_pkg::CONV_CYC - 1));

  // count fixed cycles then publish the held sample
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q  <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
      result <= '0;
      smp_q  <= '0;
    end else begin
      done <= last_w;
      if (start) begin
        busy  <= 1'b1;
        cnt_q <= '0;
        smp_q <= sample;
      end else if (last_w) begin
        busy   <= 1'b0;
        result <= smp_q;
      end else if (busy) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/adsc_port.sv
`timescale 1ns/100ps
`default_nettype none
module adsc_port (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // serial link pins, asynchronous to clk
  input  wire logic                         cs_n,
  input  wire logic                         sclk,
  input  wire logic                         serial_command_in_pin,
  output logic                              sdo_o,
  output logic                              sdo_oe,
  output logic                              status_pin,
  // converter front: digitised analog_channel_inputs
  input  wire logic [11*adsc_pkg::RES_W-1:0] analog_channel_inputs,
  // analog control
  output logic [adsc_pkg::CODE_W-1:0]       mux_sel,
  output logic                              sampling,
  output logic                              ref_internal,
  output logic                              ref_high,
  output logic                              conv_busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_CONV = 3'b100
  } adsc_state_t;

  // synchronised pins; select is carried active high so that its reset
  // value matches an idle pin and no false frame start follows reset
  logic sel_s;
  logic ck_s;
  logic di_s;
  logic cs_p_q;
  logic ck_p_q;
  adsc_sync u_cs (.clk(clk), .rstn(rstn), .d(!cs_n), .q(sel_s));
  adsc_sync u_ck (.clk(clk), .rstn(rstn), .d(sclk), .q(ck_s));
  adsc_sync u_di (.clk(clk), .rstn(rstn), .d(serial_command_in_pin), .q(di_s));

  // edge detects on synced levels
  wire cs_s    = !sel_s;
  wire cs_fall = cs_p_q && !cs_s;
  wire cs_rise = !cs_p_q && cs_s;
  wire active  = !cs_s;
  wire ck_rise = active && !ck_p_q && ck_s;
  wire ck_fall = active && ck_p_q && !ck_s;

  adsc_state_t                     st_q;
  logic [adsc_pkg::CNT_W-1:0]      rise_q;
  logic [adsc_pkg::CNT_W-1:0]      fall_q;
  logic [7:0]                      in_q;
  logic [adsc_pkg::CODE_W-1:0]     code_q;
  adsc_pkg::adsc_cfg_t             cfg_q;
  adsc_pkg::adsc_cfg2_t            cfg2_q;
  logic [adsc_pkg::RES_W-1:0]      out_q;
  logic [adsc_pkg::CNT_W-1:0]      len_q;
  logic                            samp_q;
  logic                            ord_q;

  // frame length from configuration
  wire [adsc_pkg::CNT_W-1:0] len_w =
    (cfg_q.len_sel == 2'h1) ? adsc_pkg::LEN8 :
    (cfg_q.len_sel == 2'h3) ? adsc_pkg::LEN16 : adsc_pkg::LEN12;
  wire last_fall = ck_fall && (fall_q + 1'b1 == len_q);

  // mux: analog inputs or fixed self-test levels
  wire is_ain   = mux_sel <= adsc_pkg::LAST_AIN;
  wire [adsc_pkg::RES_W-1:0] ain_w =
    analog_channel_inputs[mux_sel[3:0]*adsc_pkg::RES_W +: adsc_pkg::RES_W];
  wire [adsc_pkg::RES_W-1:0] raw_w =
    is_ain                          ? ain_w :
    (mux_sel == adsc_pkg::TEST_MID)  ? adsc_pkg::RES_MID :
    (mux_sel == adsc_pkg::TEST_ZERO) ? adsc_pkg::RES_ZERO :
    (mux_sel == adsc_pkg::TEST_FULL) ? adsc_pkg::RES_FULL : adsc_pkg::RES_ZERO;
  // bipolar flips msb to twos complement
  wire [adsc_pkg::RES_W-1:0] coded_w =
    cfg_q.bipolar ? (raw_w ^ adsc_pkg::BIPOLAR_FLIP) : raw_w;

  logic                      cv_done;
  logic [adsc_pkg::RES_W-1:0] cv_res;
  logic                      cv_busy;
  adsc_conv u_conv (
    .clk    (clk),
    .rstn   (rstn),
    .start  (last_fall),
    .sample (coded_w),
    .busy   (cv_busy),
    .done   (cv_done),
    .result (cv_res)
  );

  // first bit of previous result per configured order
  wire sdo_first = cfg_q.lsb_first ? out_q[0] : out_q[adsc_pkg::RES_W-1];

  // pin history
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_p_q <= 1'b1;
      ck_p_q <= 1'b0;
    end else begin
      cs_p_q <= cs_s;
      ck_p_q <= ck_s;
    end
  end

  // frame control state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
    end else if (cs_fall) begin
      st_q <= ST_SHIFT;
    end else if (last_fall) begin
      st_q <= ST_CONV;
    end else if (cs_rise && st_q == ST_SHIFT) begin
      st_q <= ST_IDLE;
    end else if (cv_done) begin
      st_q <= ST_IDLE;
    end
  end

  // edge counters, cleared at frame start; clock ignored while deselected
  // length and bit order are held for the frame: new configuration lands mid-frame
  always_ff @(posedge clk) begin
    if (!rstn || cs_fall) begin
      rise_q <= '0;
      fall_q <= '0;
      len_q  <= len_w;
      ord_q  <= cfg_q.lsb_first;
    end else if (st_q == ST_SHIFT) begin
      if (ck_rise) rise_q <= rise_q + 1'b1;
      if (ck_fall) fall_q <= fall_q + 1'b1;
    end
  end

  // input shift: code bits msb first, then configuration
  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_q <= '0;
    end else if (st_q == ST_SHIFT && ck_rise && rise_q < adsc_pkg::FRAME_EDGES) begin
      in_q <= {in_q[6:0], di_s};
    end
  end

  // channel applied after fourth rise, configuration after eighth
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mux_sel <= '0;
      cfg_q   <= '0;
      cfg2_q  <= '0;
      code_q  <= '0;
    end else if (st_q == ST_SHIFT && rise_q == adsc_pkg::CODE_EDGES && !ck_rise) begin
      code_q <= in_q[3:0];
      if (in_q[3:0] != adsc_pkg::CMD_CFG2) mux_sel <= in_q[3:0];
    end else if (st_q == ST_SHIFT && rise_q == adsc_pkg::FRAME_EDGES && !ck_rise) begin
      if (code_q == adsc_pkg::CMD_CFG2) cfg2_q <= in_q[3:0];
      else cfg_q <= in_q[3:0];
    end
  end

  // sample window from fourth fall to last fall
  always_ff @(posedge clk) begin
    if (!rstn || cs_fall || last_fall) begin
      samp_q <= 1'b0;
    end else if (ck_fall && fall_q + 1'b1 == adsc_pkg::CODE_EDGES) begin
      samp_q <= 1'b1;
    end
  end

  // result shifter: load at conversion done, advance on each falling edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_q <= '0;
    end else if (cv_done) begin
      out_q <= cv_res;
    end else if (ck_fall) begin
      out_q <= ord_q ? {1'b0, out_q[adsc_pkg::RES_W-1:1]}
                     : {out_q[adsc_pkg::RES_W-2:0], 1'b0};
    end
  end

  // data out: driven only while selected, changes only on falls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdo_o  <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= active;
      if (cs_fall) sdo_o <= sdo_first;
      else if (ck_fall) begin
        sdo_o <= ord_q ? out_q[1] : out_q[adsc_pkg::RES_W-2];
      end
    end
  end

  // status pin: interrupt or end-of-conversion behaviour
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_pin <= 1'b1;
    end else if (cfg2_q.status_int) begin
      if (cv_done) status_pin <= 1'b0;
      else if (ck_rise) status_pin <= 1'b1;
    end else begin
      if (last_fall) status_pin <= 1'b0;
      else if (cv_done) status_pin <= 1'b1;
    end
  end

  // analog side controls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sampling     <= 1'b0;
      ref_internal <= 1'b0;
      ref_high     <= 1'b0;
      conv_busy    <= 1'b0;
    end else begin
      sampling     <= samp_q;
      ref_internal <= cfg2_q.ref_internal;
      ref_high     <= cfg2_q.ref_high;
      conv_busy    <= cv_busy;
    end
  end
endmodule
`default_nettype wire

//--- tb/adsc_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// pin-level checks; edge ages count clocks since a raw pin edge
module adsc_port_asserts (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // link and control
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       sdo_o,
  input wire logic       sdo_oe,
  input wire logic       status_pin,
  input wire logic [3:0] mux_sel,
  input wire logic       sampling,
  input wire logic       conv_busy
);
  logic       sclk_q;
  logic [3:0] rise_q;
  logic [3:0] fall_q;
  logic [7:0] low_q;
  logic [7:0] busy_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // the port lags raw pins by its synchroniser, so ages allow a few clocks
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    rise_q <= !rstn ? 4'hF : (sclk && !sclk_q) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hF};
    fall_q <= !rstn ? 4'hF : (!sclk && sclk_q) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
    low_q  <= cs_n ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
    busy_q <= conv_busy ? busy_q + 8'h01 : 8'h00;
  end
  chk_oe_on: assert property ($fell(cs_n) |-> ##[2:8] sdo_oe)
    else $error("output not enabled after select");
  chk_oe_off: assert property ($rose(cs_n) |-> ##[2:8] !sdo_oe)
    else $error("output not released after deselect");
  chk_oe_hold: assert property (low_q > 8'h08 |-> sdo_oe)
    else $error("output released inside frame");
  chk_sdo_fall: assert property (low_q > 8'h08 && $changed(sdo_o) |-> fall_q < 4'h8)
    else $error("output bit moved without a falling clock");
  chk_mux_rise: assert property ($changed(mux_sel) |-> rise_q < 4'h8)
    else $error("channel changed without a rising clock");
  chk_samp_fall: assert property ($rose(sampling) |-> fall_q < 4'h8)
    else $error("sampling began off a falling clock");
  chk_conv_fall: assert property ($rose(conv_busy) |-> fall_q < 4'h8)
    else $error("conversion began off a falling clock");
  chk_conv_len: assert property ($fell(conv_busy) |-> busy_q >= 8'h64 && busy_q <= 8'h6C)
    else $error("conversion length wrong");
  chk_status_done: assert property ($fell(conv_busy) |-> ##[0:3] $changed(status_pin))
    else $error("status did not flag completion");
endmodule
bind adsc_port adsc_port_asserts u_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
  .sdo_o(sdo_o), .sdo_oe(sdo_oe), .status_pin(status_pin), .mux_sel(mux_sel),
  .sampling(sampling), .conv_busy(conv_busy));
`default_nettype wire

//--- tb/adsc_host.sv
`timescale 1ns/100ps
`default_nettype none
// serial host; link clock stands low between frames
module adsc_host (
  // pacing clock
  input  wire logic clk,
  // link pins
  output var logic  cs_n,
  output var logic  sclk,
  output var logic  din,
  input  wire logic sdo_o,
  input  wire logic sdo_oe
);
  logic last_q = 1'b0;
  logic sdo_w;
  // a released line shows the inverse of its last level, never a stale copy
  assign sdo_w = sdo_oe ? sdo_o : ~last_q;
  always @(posedge clk) if (sdo_oe) last_q <= sdo_o;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // one frame of n clocks; result read just before each fall
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] got);
    got = 16'h0000;
    @(posedge clk) #1 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = (i < 8) ? cmd[7-i] : i[0];
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (4) @(posedge clk);
      // read off the edge, while the bit still stands, then drop the clock
      #1 got = {got[14:0], sdo_w};
      sclk = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    din = ~din;
  endtask
endmodule
`default_nettype wire

//--- tb/adsc_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module adsc_port_bench;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic [131:0] ain = 132'h0;
  logic         cs_n, sclk, din, sdo_o, sdo_oe, status_pin;
  logic         sampling, ref_internal, ref_high, conv_busy;
  logic [3:0]   mux_sel;
  logic [11:0]  sp;
  logic         pv = 1'b0;
  logic         intm = 1'b0;
  logic [3:0]   pcfg = 4'h0;
  int           error_cnt = 0;
  int           comparisons = 0;

  always #20 clk = ~clk;

  adsc_port u_adsc_port (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
    .serial_command_in_pin(din), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .status_pin(status_pin),
    .analog_channel_inputs(ain), .mux_sel(mux_sel), .sampling(sampling),
    .ref_internal(ref_internal), .ref_high(ref_high), .conv_busy(conv_busy));
  adsc_host u_adsc_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe));

  task results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // bounded wait on status; a hang ends the run
  task automatic wait_st(input logic lvl);
    int k;
    for (k = 0; k < 400 && status_pin !== lvl; k++) @(posedge clk);
    if (status_pin !== lvl) begin
      error_cnt++;
      $display("BAD status_wait exp %0h got %0h", lvl, status_pin);
      results();
    end
  endtask

  // one frame; the result seen belongs to the frame before
  task automatic run(input logic [3:0] code, input logic [3:0] cfg);
    int          n;
    int          k;
    logic [15:0] got;
    logic [11:0] v;
    // length is the one latched at select, from the last configuring frame
    n = !pcfg[2] ? 12 : (pcfg[3] ? 16 : 8);
    k = (n < 12) ? n : 12;
    u_adsc_host.xfer({code, cfg}, n, got);
    if (pv) `CHK("result", {4'h0, sp} >> (12 - k), got >> (n - k))
    if (code == adsc_pkg::CMD_CFG2) begin
      repeat (adsc_pkg::CONV_CYC + 20) @(posedge clk);
      pv = 1'b0;
    end else begin
      repeat (4) @(posedge clk);
      #1;
      `CHK("mux_sel", code, mux_sel)
      // mid conversion: end mode shows low, interrupt mode was raised by the clock
      `CHK("status", intm, status_pin)
      wait_st(~intm);
      v = (code == adsc_pkg::TEST_MID) ? adsc_pkg::RES_MID :
          (code == adsc_pkg::TEST_FULL) ? adsc_pkg::RES_FULL : adsc_pkg::RES_ZERO;
      if (code <= adsc_pkg::LAST_AIN) v = ain[code*12 +: 12];
      if (cfg[1]) v = v ^ adsc_pkg::BIPOLAR_FLIP;
      for (int b = 0; b < 12; b++) sp[b] = cfg[0] ? v[11-b] : v[b];
      pv = 1'b1;
      pcfg = cfg;
    end
  endtask

  initial begin
    for (int c = 0; c < 11; c++) ain[c*12 +: 12] = 12'(12'h01A5 + c * 12'h00B3);
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    `CHK("status_rst", 1'b1, status_pin)
    `CHK("oe_rst", 1'b0, sdo_oe)
    `CHK("ref_rst", 2'b00, {ref_internal, ref_high})
    repeat (3) @(posedge clk);
    // every channel and self-test code; order and coding vary on analog ones
    for (int c = 0; c < 14; c++) run(4'(c), (c < 11) ? 4'(c & 3) : 4'h0);
    $display("test channels done");
    // each length takes effect on the frame after the one that set it
    run(4'h5, 4'h4);
    run(4'h6, 4'hC);
    run(4'hE, 4'h8);
    $display("test lengths done");
    run(4'hF, 4'hE);
    `CHK("ref_ctl", 2'b11, {ref_internal, ref_high})
    intm = 1'b1;
    run(4'hD, 4'h0);
    run(4'hC, 4'h0);
    run(4'hF, 4'h4);
    `CHK("ref_ctl", 2'b10, {ref_internal, ref_high})
    intm = 1'b0;
    run(4'h2, 4'h0);
    run(4'h3, 4'h0);
    $display("test config done");
    results();
  end
endmodule
`default_nettype wire
